// ### shared/spmon_pkg.sv
// package: register map, field layout and timing constants for the protection monitors
package spmon_pkg;
  // ==========================================
  // register indices on the plain register port
  localparam logic [3:0] SPMON_ADDR_PCR     = 4'h0;  // protection_control_reg
  localparam logic [3:0] SPMON_ADDR_WDSVC   = 4'h1;  // watchdog_service_reg
  localparam logic [3:0] SPMON_ADDR_RSTCAUS = 4'h2;  // reset_cause_reg

  // ==========================================
  // protection control field positions
  localparam int SPMON_BIT_WDEN  = 7;
  localparam int SPMON_BIT_WDPRE = 6;
  localparam int SPMON_BIT_WDT_H = 5;
  localparam int SPMON_BIT_WDT_L = 4;
  localparam int SPMON_BIT_STALL = 3;
  localparam int SPMON_BIT_EXTBM = 2;
  localparam int SPMON_BIT_BMT_H = 1;
  localparam int SPMON_BIT_BMT_L = 0;

  // reset values
  localparam logic       SPMON_RST_WDEN  = 1'b1;
  localparam logic [1:0] SPMON_RST_WDT   = 2'h0;
  localparam logic       SPMON_RST_STALL = 1'b0;
  localparam logic       SPMON_RST_EXTBM = 1'b0;
  localparam logic [1:0] SPMON_RST_BMT   = 2'h0;

  // reset cause bits
  localparam int SPMON_CAUSE_WDOG = 0;
  localparam int SPMON_CAUSE_HALT = 1;

  // ==========================================
  // service key values
  localparam logic [7:0] SPMON_KEY_ARM  = 8'h55;
  localparam logic [7:0] SPMON_KEY_FIRE = 8'hAA;

  // ==========================================
  // watchdog divide exponents
  localparam logic [4:0] SPMON_WD_EXP0 = 5'd9;
  localparam logic [4:0] SPMON_WD_EXP1 = 5'd11;
  localparam logic [4:0] SPMON_WD_EXP2 = 5'd13;
  localparam logic [4:0] SPMON_WD_EXP3 = 5'd15;
  localparam logic [4:0] SPMON_WD_EXP4 = 5'd18;
  localparam logic [4:0] SPMON_WD_EXP5 = 5'd20;
  localparam logic [4:0] SPMON_WD_EXP6 = 5'd22;
  localparam logic [4:0] SPMON_WD_EXP7 = 5'd24;
  localparam int         SPMON_WD_W    = 25;

  // bus monitor limits in system clocks
  localparam logic [6:0] SPMON_BM_LIM0 = 7'd64;
  localparam logic [6:0] SPMON_BM_LIM1 = 7'd32;
  localparam logic [6:0] SPMON_BM_LIM2 = 7'd16;
  localparam logic [6:0] SPMON_BM_LIM3 = 7'd8;

  // synchroniser depth for pins
  localparam int SPMON_SYNC_N = 3;

  typedef enum logic [1:0] {SPMON_BM_IDLE, SPMON_BM_RUN, SPMON_BM_ERR} spmon_bm_state_t;
endpackage

// ### rtl/spmon_sync.sv
// three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/10ps
module spmon_sync
  import spmon_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [SPMON_SYNC_N-1:0] stage_r;
  logic [SPMON_SYNC_N-1:0] stage_nxt;
  logic                    level_r;
  logic                    level_nxt;

  always_comb begin
    stage_nxt = {stage_r[SPMON_SYNC_N-2:0], pin_in};
    level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
  end

  // stages run through reset, so the strap level is settled at release
  always_ff @(posedge clk) begin
    stage_r <= stage_nxt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule // spmon_sync

// ### rtl/spmon_busmon.sv
// bus monitor: times acknowledge response of monitored cycles
`timescale 1ns/10ps
module spmon_busmon
  import spmon_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cyc_start,
  input  wire logic       cyc_monitored,
  input  wire logic       cyc_end,
  input  wire logic [1:0] bm_timing,
  output logic            timeout_pulse
);
  spmon_bm_state_t state_r;
  spmon_bm_state_t state_nxt;
  logic [6:0]      cnt_r;
  logic [6:0]      cnt_nxt;
  logic [6:0]      limit;

  always_comb begin
    case (bm_timing)
      2'h0:    limit = SPMON_BM_LIM0;
      2'h1:    limit = SPMON_BM_LIM1;
      2'h2:    limit = SPMON_BM_LIM2;
      default: limit = SPMON_BM_LIM3;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      SPMON_BM_IDLE: begin
        if (cyc_start && cyc_monitored) begin
          state_nxt = SPMON_BM_RUN;
          cnt_nxt   = '0;
        end
      end
      SPMON_BM_RUN: begin
        if (cyc_end) begin
          state_nxt = SPMON_BM_IDLE;
        end else if (cnt_r == limit - 7'd1) begin
          state_nxt = SPMON_BM_ERR;
        end else begin
          cnt_nxt = cnt_r + 7'd1;
        end
      end
      SPMON_BM_ERR: state_nxt = SPMON_BM_IDLE;
      default:      state_nxt = SPMON_BM_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SPMON_BM_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign timeout_pulse = (state_r == SPMON_BM_ERR);

  a_bm_unmon: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == SPMON_BM_IDLE && cyc_start && !cyc_monitored |=> state_r == SPMON_BM_IDLE)
    else $error("unmonitored cycle started the timer");
  a_bm_limit: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == SPMON_BM_RUN && !cyc_end && cnt_r == limit - 7'd1 |=> timeout_pulse)
    else $error("limit reached without timeout");
endmodule // spmon_busmon

// ### rtl/spmon_top.sv
// system protection monitors: watchdog, bus, halt and spurious interrupt monitors
// Functional notes
// - unprescaled watchdog ratios 2^9 to 2^15
// - prescaled watchdog ratios 2^18 to 2^24
// - halt reset only when stall enable set
// - external cycles monitored only when enabled
// - acknowledge limit 64/32/16/8 clocks
// - slow acknowledge raises bus error
// - non-core external cycles not timed
// - halt request resets and flags cause
// - unarbitrated interrupt acknowledge raises bus error
// - watchdog runs only when enabled
// - unserviced watchdog expiry resets system
// - service writes always taken, reads zero
// - 0x55 then 0xAA restarts timeout
// - new timing applies after service
// - prescale reset from inverted mode strap
// - control register writable once after reset
// - enable bit one enables watchdog
`timescale 1ns/10ps
module spmon_top
  import spmon_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       clock_mode_strap,
  input  wire logic       cyc_start,
  input  wire logic       cyc_external,
  input  wire logic       cyc_by_core,
  input  wire logic       cyc_int_ack,
  input  wire logic       transfer_size_ack,
  input  wire logic       autovector_ack,
  input  wire logic       cyc_terminated,
  input  wire logic       int_arbitrated,
  input  wire logic       halt_request,
  output logic            bus_error,
  output logic            sys_reset_req
);
  // ==========================================
  // pin synchronisers
  logic strap_s;
  logic halt_s;

  spmon_sync u_sync_strap (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (clock_mode_strap),
    .level_out (strap_s)
  );

  spmon_sync u_sync_halt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_in    (halt_request),
    .level_out (halt_s)
  );

  // ==========================================
  // protection control register
  logic       wd_en_r,     wd_en_nxt;
  logic       wd_pre_r,    wd_pre_nxt;
  logic [1:0] wd_tim_r,    wd_tim_nxt;
  logic       stall_en_r,  stall_en_nxt;
  logic       ext_bm_en_r, ext_bm_en_nxt;
  logic [1:0] bm_tim_r,    bm_tim_nxt;
  logic       pcr_lock_r,  pcr_lock_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [1:0] cause_r,     cause_nxt;
  logic [7:0] rdata_r,     rdata_nxt;
  logic       pcr_wr;

  assign pcr_wr = reg_wr && (reg_addr == SPMON_ADDR_PCR);

  always_comb begin
    wd_en_nxt     = wd_en_r;
    wd_pre_nxt    = wd_pre_r;
    wd_tim_nxt    = wd_tim_r;
    stall_en_nxt  = stall_en_r;
    ext_bm_en_nxt = ext_bm_en_r;
    bm_tim_nxt    = bm_tim_r;
    pcr_lock_nxt  = pcr_lock_r;
    strap_cnt_nxt = strap_cnt_r;
    // strap settles through the synchroniser before being caught
    if (strap_cnt_r != 2'h3) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h2 && !pcr_lock_r) begin
        wd_pre_nxt = ~strap_s;
      end
    end
    if (pcr_wr && !pcr_lock_r) begin
      pcr_lock_nxt  = 1'b1;
      wd_en_nxt     = reg_wdata[SPMON_BIT_WDEN];
      wd_pre_nxt    = reg_wdata[SPMON_BIT_WDPRE];
      wd_tim_nxt    = reg_wdata[SPMON_BIT_WDT_H:SPMON_BIT_WDT_L];
      stall_en_nxt  = reg_wdata[SPMON_BIT_STALL];
      ext_bm_en_nxt = reg_wdata[SPMON_BIT_EXTBM];
      bm_tim_nxt    = reg_wdata[SPMON_BIT_BMT_H:SPMON_BIT_BMT_L];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_en_r     <= SPMON_RST_WDEN;
      wd_pre_r    <= 1'b0;
      wd_tim_r    <= SPMON_RST_WDT;
      stall_en_r  <= SPMON_RST_STALL;
      ext_bm_en_r <= SPMON_RST_EXTBM;
      bm_tim_r    <= SPMON_RST_BMT;
      pcr_lock_r  <= 1'b0;
      strap_cnt_r <= 2'h0;
    end else begin
      wd_en_r     <= wd_en_nxt;
      wd_pre_r    <= wd_pre_nxt;
      wd_tim_r    <= wd_tim_nxt;
      stall_en_r  <= stall_en_nxt;
      ext_bm_en_r <= ext_bm_en_nxt;
      bm_tim_r    <= bm_tim_nxt;
      pcr_lock_r  <= pcr_lock_nxt;
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  // ==========================================
  // watchdog
  logic                   armed_r,   armed_nxt;
  logic [2:0]             act_sel_r, act_sel_nxt;
  logic [SPMON_WD_W-1:0]  wd_cnt_r,  wd_cnt_nxt;
  logic                   wd_exp_r,  wd_exp_nxt;
  logic [4:0]             wd_exp_bits;
  logic                   svc_wr;
  logic                   serviced;

  assign svc_wr   = reg_wr && (reg_addr == SPMON_ADDR_WDSVC);
  assign serviced = svc_wr && armed_r && (reg_wdata == SPMON_KEY_FIRE);

  always_comb begin
    case (act_sel_r)
      3'h0:    wd_exp_bits = SPMON_WD_EXP0;
      3'h1:    wd_exp_bits = SPMON_WD_EXP1;
      3'h2:    wd_exp_bits = SPMON_WD_EXP2;
      3'h3:    wd_exp_bits = SPMON_WD_EXP3;
      3'h4:    wd_exp_bits = SPMON_WD_EXP4;
      3'h5:    wd_exp_bits = SPMON_WD_EXP5;
      3'h6:    wd_exp_bits = SPMON_WD_EXP6;
      default: wd_exp_bits = SPMON_WD_EXP7;
    endcase
  end

  always_comb begin
    armed_nxt   = armed_r;
    act_sel_nxt = act_sel_r;
    wd_cnt_nxt  = wd_cnt_r;
    wd_exp_nxt  = 1'b0;
    if (svc_wr) begin
      if (reg_wdata == SPMON_KEY_ARM) begin
        armed_nxt = 1'b1;
      end else begin
        armed_nxt = 1'b0;
      end
    end
    // until the one control write the period tracks the reset fields, so a
    // strapped prescale counts from release; afterwards only a service or a cleared enable bit moves it
    if (!pcr_lock_r) begin
      act_sel_nxt = {wd_pre_r, wd_tim_r};
    end
    if (!wd_en_r) begin
      wd_cnt_nxt  = '0;
      act_sel_nxt = {wd_pre_r, wd_tim_r};
    end else if (serviced) begin
      wd_cnt_nxt  = '0;
      act_sel_nxt = {wd_pre_r, wd_tim_r};
    end else if (wd_cnt_r == (SPMON_WD_W'(1) << wd_exp_bits) - SPMON_WD_W'(1)) begin
      wd_exp_nxt = 1'b1;
      wd_cnt_nxt = '0;
    end else begin
      wd_cnt_nxt = wd_cnt_r + SPMON_WD_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_r   <= 1'b0;
      act_sel_r <= 3'h0;
      wd_cnt_r  <= '0;
      wd_exp_r  <= 1'b0;
    end else begin
      armed_r   <= armed_nxt;
      act_sel_r <= act_sel_nxt;
      wd_cnt_r  <= wd_cnt_nxt;
      wd_exp_r  <= wd_exp_nxt;
    end
  end

  // ==========================================
  // bus and spurious interrupt monitors
  logic cyc_mon;
  logic cyc_end;
  logic bm_to;
  logic spur;
  logic bus_error_r, bus_error_nxt;

  // internal cycles always monitored; external only when core-started and enabled
  assign cyc_mon = !cyc_external || (cyc_by_core && ext_bm_en_r);
  assign cyc_end = transfer_size_ack || cyc_terminated || (cyc_int_ack && autovector_ack);
  assign spur    = cyc_int_ack && cyc_end && !int_arbitrated;

  spmon_busmon u_busmon (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cyc_start     (cyc_start),
    .cyc_monitored (cyc_mon),
    .cyc_end       (cyc_end),
    .bm_timing     (bm_tim_r),
    .timeout_pulse (bm_to)
  );

  assign bus_error_nxt = bm_to || spur;

  // ==========================================
  // reset requests, reset cause and read port
  logic rst_req_r, rst_req_nxt;
  logic halt_rst;

  assign halt_rst    = halt_s && stall_en_r;
  assign rst_req_nxt = wd_exp_r || halt_rst;

  always_comb begin
    cause_nxt = cause_r;
    if (wd_exp_r || halt_rst) begin
      cause_nxt[SPMON_CAUSE_WDOG] = wd_exp_r;
      cause_nxt[SPMON_CAUSE_HALT] = halt_rst;
    end
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        SPMON_ADDR_PCR:
          rdata_nxt = {wd_en_r, wd_pre_r, wd_tim_r, stall_en_r, ext_bm_en_r, bm_tim_r};
        SPMON_ADDR_RSTCAUS: rdata_nxt = {6'h00, cause_r};
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  // cause survives the system reset it triggers; nothing clears it, only a later reset event overwrites it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_req_r <= 1'b0;
      bus_error_r    <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      rst_req_r <= rst_req_nxt;
      bus_error_r    <= bus_error_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    cause_r <= cause_nxt;
  end

  assign reg_rdata     = rdata_r;
  assign bus_error     = bus_error_r;
  assign sys_reset_req = rst_req_r;

  // ==========================================
  // checks: control register
  a_pcr_write_once: assert property (@(posedge clk) disable iff (sys_rst)
    pcr_lock_r && pcr_wr |=> $stable(bm_tim_r) && $stable(wd_en_r))
    else $error("control register changed after lock");
  a_pcr_first: assert property (@(posedge clk) disable iff (sys_rst)
    pcr_wr && !pcr_lock_r |=> pcr_lock_r
      && {wd_en_r, wd_pre_r, wd_tim_r, stall_en_r, ext_bm_en_r, bm_tim_r} == $past(reg_wdata))
    else $error("first control write not taken");
  a_strap_capture: assert property (@(posedge clk) disable iff (sys_rst)
    strap_cnt_r == 2'h2 && !pcr_lock_r && !pcr_wr |=> wd_pre_r == !$past(strap_s))
    else $error("prescale not loaded from inverted strap");

  // ==========================================
  // checks: watchdog
  a_wd_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    !wd_en_r |=> wd_cnt_r == '0)
    else $error("watchdog counts while disabled");
  a_wd_counts: assert property (@(posedge clk) disable iff (sys_rst)
    wd_en_r && !serviced && !wd_exp_nxt |=> wd_cnt_r == $past(wd_cnt_r) + SPMON_WD_W'(1))
    else $error("enabled watchdog not counting");
  a_wd_service: assert property (@(posedge clk) disable iff (sys_rst)
    wd_en_r && serviced |=> wd_cnt_r == '0
      && act_sel_r[2] == $past(wd_pre_r) && act_sel_r[1:0] == $past(wd_tim_r))
    else $error("service did not restart watchdog");
  a_wd_old_period: assert property (@(posedge clk) disable iff (sys_rst)
    wd_en_r && !serviced && pcr_lock_r |=> $stable(act_sel_r))
    else $error("period changed without service");
  a_wd_reset: assert property (@(posedge clk) disable iff (sys_rst)
    wd_exp_r |=> sys_reset_req && cause_r[SPMON_CAUSE_WDOG])
    else $error("expiry did not reset");
  a_arm_key: assert property (@(posedge clk) disable iff (sys_rst)
    svc_wr && reg_wdata == SPMON_KEY_ARM |=> armed_r)
    else $error("first key did not arm");
  a_arm_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !svc_wr |=> $stable(armed_r))
    else $error("armed state moved without service write");
  a_bad_key: assert property (@(posedge clk) disable iff (sys_rst)
    svc_wr && reg_wdata != SPMON_KEY_ARM |=> !armed_r)
    else $error("sequence stays armed after wrong key");

  // ==========================================
  // checks: reads, reset requests and bus error
  // cause_r powers up unknown, so no check reads it before an event sets it
  a_svc_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == SPMON_ADDR_WDSVC |=> reg_rdata == 8'h00)
    else $error("service register read not zero");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_halt_gated: assert property (@(posedge clk) disable iff (sys_rst)
    !stall_en_r && !wd_exp_r |=> !sys_reset_req)
    else $error("halt reset while disabled");
  a_halt_reset: assert property (@(posedge clk) disable iff (sys_rst)
    halt_s && stall_en_r |=> sys_reset_req && cause_r[SPMON_CAUSE_HALT])
    else $error("halt did not reset or flag cause");
  a_rst_source: assert property (@(posedge clk) disable iff (sys_rst)
    !wd_exp_r && !halt_rst |=> !sys_reset_req)
    else $error("reset request without a cause");
  a_spur_bus_error: assert property (@(posedge clk) disable iff (sys_rst)
    spur |=> bus_error)
    else $error("spurious acknowledge without bus error");
  a_slow_bus_error: assert property (@(posedge clk) disable iff (sys_rst)
    bm_to |=> bus_error)
    else $error("slow acknowledge without bus error");
  a_ext_unmon: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && cyc_external && !ext_bm_en_r |-> !cyc_mon)
    else $error("external cycle monitored while disabled");
endmodule // spmon_top

// ### sim/spmon_bus_partner.sv
// far side model: core-started and other bus cycles, acknowledged after a set delay
`timescale 1ns/10ps
module spmon_bus_partner (
  input  wire logic clk,
  output logic      cyc_start,
  output logic      cyc_external,
  output logic      cyc_by_core,
  output logic      cyc_int_ack,
  output logic      transfer_size_ack,
  output logic      autovector_ack,
  output logic      cyc_terminated,
  output logic      int_arbitrated
);
  initial begin
    {cyc_start, cyc_external, cyc_by_core, cyc_int_ack} = 4'h0;
    {transfer_size_ack, autovector_ack, cyc_terminated, int_arbitrated} = 4'h0;
  end

  // ==========================================
  // one bus cycle; k picks the ending: 0 size ack, 1 autovector, 2 terminate
  task automatic run(input logic ext, input logic core, input logic iack, input logic arb,
                     input logic [1:0] k, input int dly);
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_external <= ext;
    cyc_by_core <= core;
    cyc_int_ack <= iack;
    int_arbitrated <= arb;
    repeat (dly) begin
      @(posedge clk);
      cyc_start <= 1'b0;
    end
    transfer_size_ack <= (k == 2'h0);
    autovector_ack <= (k == 2'h1);
    cyc_terminated <= (k == 2'h2);
    @(posedge clk);
    {transfer_size_ack, autovector_ack, cyc_terminated} <= 3'h0;
    // qualifiers dropped only after the ending edge, so arbitration is seen with it
    {cyc_external, cyc_by_core, cyc_int_ack, int_arbitrated} <= 4'h0;
  endtask
endmodule // spmon_bus_partner

// ### sim/tb_spmon_top.sv
// bench top: drives registers, pins and bus cycles, checks reads and monitor events
`timescale 1ns/10ps
module tb_spmon_top
  import spmon_pkg::*;
;
  typedef struct packed {logic [7:0] d; logic [7:0] m;} spmon_exp_t;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, strap = 1'b1, halt_request = 1'b0;
  logic rd_d = 1'b0, rst_q = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic cyc_start, cyc_external, cyc_by_core, cyc_int_ack, transfer_size_ack, autovector_ack;
  logic cyc_terminated, int_arbitrated, bus_error, sys_reset_req;
  int n_mismatch = 0, checked = 0, cyc = 0, n_bus_error = 0, n_rst = 0, t0, nb;
  spmon_exp_t expq[$];
  spmon_exp_t e;

  spmon_top u_spmon_top (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .clock_mode_strap  (strap),
    .cyc_start         (cyc_start),
    .cyc_external      (cyc_external),
    .cyc_by_core       (cyc_by_core),
    .cyc_int_ack       (cyc_int_ack),
    .transfer_size_ack (transfer_size_ack),
    .autovector_ack    (autovector_ack),
    .cyc_terminated    (cyc_terminated),
    .int_arbitrated    (int_arbitrated),
    .halt_request      (halt_request),
    .bus_error         (bus_error),
    .sys_reset_req     (sys_reset_req)
  );

  spmon_bus_partner u_spmon_bus_partner (
    .clk               (clk),
    .cyc_start         (cyc_start),
    .cyc_external      (cyc_external),
    .cyc_by_core       (cyc_by_core),
    .cyc_int_ack       (cyc_int_ack),
    .transfer_size_ack (transfer_size_ack),
    .autovector_ack    (autovector_ack),
    .cyc_terminated    (cyc_terminated),
    .int_arbitrated    (int_arbitrated)
  );

  always #4 clk = ~clk;

  // ==========================================
  // monitors
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // sampled mid-cycle, where registered outputs have settled
  always @(negedge clk) begin
    if (bus_error === 1'b1) n_bus_error++;
    if (sys_reset_req === 1'b1 && !rst_q) n_rst++;
    rst_q = (sys_reset_req === 1'b1);
    if (rd_d) begin
      e = expq.pop_front();
      chk_rd(e.d, reg_rdata & e.m);
    end
  end

  // ==========================================
  // compare and bus tasks
  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch read at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk_evt(input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch event at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    expq.push_back({d & m, m});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic do_rst(input logic s);
    @(posedge clk);
    sys_rst <= 1'b1;
    strap <= s;
    halt_request <= 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // strap held steady well past the capture edge
    repeat (4) @(posedge clk);
  endtask

  task automatic bus(input logic ext, input logic core, input logic iack, input logic arb,
                     input logic [1:0] k, input int dly, input logic exp);
    nb = n_bus_error;
    u_spmon_bus_partner.run(ext, core, iack, arb, k, dly);
    repeat (4) @(posedge clk);
    chk_evt(exp, n_bus_error != nb);
  endtask

  task automatic wait_rst(input int lim);
    for (int i = 0; i < lim && sys_reset_req !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h30aa_8725));
    do_rst(1'b1);
    rd(SPMON_ADDR_PCR, 8'h80, 8'hFF);
    rd(SPMON_ADDR_WDSVC, 8'h00, 8'hFF);
    rd(4'h3, 8'h00, 8'hFF);
    wr(SPMON_ADDR_PCR, 8'h07);
    wr(SPMON_ADDR_PCR, 8'hFF);
    rd(SPMON_ADDR_PCR, 8'h07, 8'hFF);
    wr(SPMON_ADDR_WDSVC, 8'h5A);
    rd(SPMON_ADDR_WDSVC, 8'h00, 8'hFF);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 1 + $urandom % 6, 1'b0);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 20, 1'b1);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 5, 1'b0);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 6, 1'b0);
    bus(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 20, 1'b0);
    bus(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 20, 1'b1);
    bus(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 20, 1'b1);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 2, 1'b1);
    bus(1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 2, 1'b0);
    @(posedge clk);
    halt_request <= 1'b1;
    repeat (30) @(posedge clk);
    chk_evt(1'b0, sys_reset_req);
    nb = n_rst;
    repeat (1200) @(posedge clk);
    chk_evt(1'b0, n_rst != nb);
    do_rst(1'b0);
    rd(SPMON_ADDR_PCR, 8'hC0, 8'hFF);
    wr(SPMON_ADDR_PCR, 8'h98);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 70, 1'b1);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 50, 1'b0);
    bus(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 70, 1'b0);
    bus(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 70, 1'b0);
    nb = n_rst;
    // gaps stay below the new 2^11 period once the first service applies it
    repeat (3) begin
      wr(SPMON_ADDR_WDSVC, SPMON_KEY_ARM);
      rd(SPMON_ADDR_PCR, 8'h98, 8'hFF);
      wr(SPMON_ADDR_WDSVC, SPMON_KEY_FIRE);
      repeat (1500) @(posedge clk);
    end
    chk_evt(1'b0, n_rst != nb);
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_ARM);
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_FIRE);
    t0 = cyc;
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_ARM);
    wr(SPMON_ADDR_WDSVC, 8'($urandom_range(84, 0)));
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_FIRE);
    wait_rst(2200);
    chk_evt(1'b1, sys_reset_req === 1'b1 && (cyc - t0) inside {[2040:2060]});
    do_rst(1'b1);
    rd(SPMON_ADDR_RSTCAUS, 8'h01, 8'h01);
    t0 = cyc;
    wr(SPMON_ADDR_PCR, 8'h9B);
    wait_rst(1500);
    chk_evt(1'b1, sys_reset_req === 1'b1 && (cyc - t0) < 1000);
    do_rst(1'b1);
    wr(SPMON_ADDR_PCR, 8'h88);
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_ARM);
    wr(SPMON_ADDR_WDSVC, SPMON_KEY_FIRE);
    @(posedge clk);
    halt_request <= 1'b1;
    wait_rst(12);
    chk_evt(1'b1, sys_reset_req);
    do_rst(1'b1);
    rd(SPMON_ADDR_RSTCAUS, 8'h02, 8'h02);
    stop_test();
  end
endmodule // tb_spmon_top
